// File: design/clock_safeguard_and_reset_input.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`include "clk_safeguard_cfg.svh"
// Notes on behaviour
// - timer, converter and watchdog clock enable is internal clock divided by 12
// - core machine cycle is internal clock divided by 13
// - instructions take two, four or five machine cycles
// - with safeguard, stop bit halts main oscillator and starts backup
// - clearing stop bit or any reset turns main oscillator back on
// - main resumes after start-up delay plus current instruction on backup
// - backup starts one own period after first missing main edge
// - on backup everything runs normally, just slower
// - at power on, backup clocks the reset delay counter
// - backup stops when main oscillator takes over the internal clock
// - safeguard drops spikes so internal clock stays below its limit
// - control register bit 2 alone acts; other bits have no function
// - reset from pin, power-on, watchdog or low-voltage detector
// - reset pin is stretched by an internal delay, short pulses count
// - reset stays while pin is low, in any mode
// - reset halts core, pulls up all pins, restarts main oscillator
// - reset in stop mode starts oscillator and pulls up pins
// - initialisation starts only when the internal delay has expired
// - safeguard and backup oscillator exist only when option bit set
// - initialisation clears stack and loads program counter with reset vector
module clock_safeguard_and_reset_input #(
  parameter int RESET_DELAY_TICKS = `RESET_DELAY_TICKS
) (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  // apb slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [11:0]                      paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // oscillator pins and options
  input  wire logic                             main_osc_in,
  input  wire logic                             safeguard_enable_option,
  output logic                                  main_osc_enable,
  output logic                                  backup_osc_enable,
  // reset sources
  input  wire logic                             reset_pin_n,
  input  wire logic                             power_on_req,
  input  wire logic                             watchdog_timeout,
  input  wire logic                             low_voltage_req,
  // core interface
  input  clk_safeguard_pkg::instr_len_t         instr_len,
  output clk_safeguard_pkg::clk_ticks_t         ticks,
  output clk_safeguard_pkg::rst_out_t           rst_out
);

  // ============================================================
  // constants at the width of what they meet
  localparam logic [7:0]  BACKUP_CYC  = 8'(`BACKUP_PERIOD_CYC);
  localparam logic [7:0]  MISS_CYC    = 8'(`MISS_EDGE_CYC);
  localparam logic [3:0]  GAP_CYC     = 4'(`OSG_MIN_PERIOD_CYC);
  localparam logic [7:0]  STARTUP_CYC = 8'(`OSC_STARTUP_CYC);
  localparam logic [15:0] RST_TICKS   = 16'(RESET_DELAY_TICKS);

  clk_safeguard_pkg::state_t s_reg;
  clk_safeguard_pkg::state_t s_next;

  // decoded machine cycles per instruction
  function automatic logic [2:0] instr_cycles(input clk_safeguard_pkg::instr_len_t len);
    case (len)
      clk_safeguard_pkg::LEN_TWO:  instr_cycles = `INSTR_CYC_SHORT;
      clk_safeguard_pkg::LEN_FOUR: instr_cycles = `INSTR_CYC_MID;
      default:                     instr_cycles = `INSTR_CYC_LONG;
    endcase
  endfunction

  // stop bit active only when the safeguard option is fitted
  function automatic logic stop_req(input logic [7:0] ctl, input logic oscillator_safeguard);
    stop_req = oscillator_safeguard & ctl[`MAIN_OSC_STOP_BIT];
  endfunction

  // combinational helpers
  logic main_edge;
  logic bk_tick;
  logic raw_tick;
  logic int_tick;
  logic any_src;
  logic want_main;
  logic apb_setup;
  logic apb_write;
  logic addr_hit;

  // ============================================================
  // next-state logic
  always_comb
  begin
    s_next    = s_reg;
    want_main = 1'b0;
    apb_setup = psel & ~penable;
    apb_write = psel & penable & pwrite;
    addr_hit  = (paddr == `CONV_CTL_ADDR);

    // pin synchronisers
    s_next.rst_s1   = reset_pin_n;
    s_next.rst_s2   = s_reg.rst_s1;
    s_next.osc_s1   = main_osc_in;
    s_next.osc_s2   = s_reg.osc_s1;
    s_next.osc_prev = s_reg.osc_s2;
    main_edge       = s_reg.osc_s2 & ~s_reg.osc_prev;

    // missing-edge watch on the main oscillator
    if (main_edge)
    begin
      s_next.miss_cnt  = 8'h00;
      s_next.main_lost = 1'b0;
    end
    else if (s_reg.miss_cnt >= MISS_CYC - 8'h01)
    begin
      s_next.main_lost = 1'b1;
    end
    else
    begin
      s_next.miss_cnt = s_reg.miss_cnt + 8'h01;
    end

    // backup oscillator, runs only while it drives the internal clock
    bk_tick = 1'b0;
    if (backup_osc_enable)
    begin
      if (s_reg.bk_cnt >= BACKUP_CYC - 8'h01)
      begin
        s_next.bk_cnt = 8'h00;
        bk_tick       = 1'b1;
      end
      else
      begin
        s_next.bk_cnt = s_reg.bk_cnt + 8'h01;
      end
    end
    else
    begin
      s_next.bk_cnt = 8'h00;  // full period before the first backup tick
    end

    // source switching
    raw_tick = s_reg.main_sel ? main_edge : bk_tick;
    if (!safeguard_enable_option)
    begin
      s_next.main_sel = 1'b1;
      s_next.rs_state = clk_safeguard_pkg::RS_IDLE;
    end
    else if (s_reg.main_sel)
    begin
      // leave main on stop request or first missing edge, no pulse cut
      if (stop_req(s_reg.ctl_reg, 1'b1) || s_reg.main_lost)
      begin
        s_next.main_sel = 1'b0;
      end
    end
    else
    begin
      want_main = ~stop_req(s_reg.ctl_reg, 1'b1) & ~s_reg.main_lost;
      case (s_reg.rs_state)
        clk_safeguard_pkg::RS_IDLE:
        begin
          if (want_main)
          begin
            s_next.rs_state  = clk_safeguard_pkg::RS_STARTUP;
            s_next.start_cnt = 8'h00;
          end
        end
        clk_safeguard_pkg::RS_STARTUP:
        begin
          if (!want_main)
          begin
            s_next.rs_state = clk_safeguard_pkg::RS_IDLE;
          end
          else if (s_reg.start_cnt >= STARTUP_CYC - 8'h01)
          begin
            s_next.rs_state = clk_safeguard_pkg::RS_WAIT_INSTR;
          end
          else
          begin
            s_next.start_cnt = s_reg.start_cnt + 8'h01;
          end
        end
        clk_safeguard_pkg::RS_WAIT_INSTR:
        begin
          if (!want_main)
          begin
            s_next.rs_state = clk_safeguard_pkg::RS_IDLE;
          end
          // hand over just after the backup tick that ends an instruction, or on any backup tick while in reset
          else if (s_reg.ticks.instr_done || (s_reg.in_reset && bk_tick))
          begin
            s_next.main_sel = 1'b1;
            s_next.rs_state = clk_safeguard_pkg::RS_IDLE;
          end
        end
        default:
        begin
          s_next.rs_state = clk_safeguard_pkg::RS_IDLE;
        end
      endcase
    end

    // spike and over-frequency filter
    int_tick = raw_tick;
    if (safeguard_enable_option && s_reg.gap_cnt < GAP_CYC - 4'h1)
    begin
      int_tick = 1'b0;
    end
    if (int_tick)
    begin
      s_next.gap_cnt = 4'h0;
    end
    else if (s_reg.gap_cnt != 4'hF)
    begin
      s_next.gap_cnt = s_reg.gap_cnt + 4'h1;
    end

    // divide by 12 for timer, converter and watchdog
    s_next.ticks.int_tick    = int_tick;
    s_next.ticks.periph_tick = 1'b0;
    if (int_tick)
    begin
      if (s_reg.p12_cnt >= `PERIPH_DIV - 4'h1)
      begin
        s_next.p12_cnt           = 4'h0;
        s_next.ticks.periph_tick = 1'b1;
      end
      else
      begin
        s_next.p12_cnt = s_reg.p12_cnt + 4'h1;
      end
    end

    // divide by 13 for the core machine cycle
    s_next.ticks.mcycle_tick = 1'b0;
    s_next.ticks.instr_done  = 1'b0;
    if (int_tick && !s_reg.in_reset)
    begin
      if (s_reg.c13_cnt >= `CORE_DIV - 4'h1)
      begin
        s_next.c13_cnt           = 4'h0;
        s_next.ticks.mcycle_tick = 1'b1;
        if (s_reg.mc_cnt >= instr_cycles(instr_len) - 3'h1)
        begin
          s_next.mc_cnt           = 3'h0;
          s_next.ticks.instr_done = 1'b1;
        end
        else
        begin
          s_next.mc_cnt = s_reg.mc_cnt + 3'h1;
        end
      end
      else
      begin
        s_next.c13_cnt = s_reg.c13_cnt + 4'h1;
      end
    end
    else if (s_reg.in_reset)
    begin
      s_next.c13_cnt = 4'h0;
      s_next.mc_cnt  = 3'h0;
    end

    // reset sources and stretch
    any_src = ~s_reg.rst_s2 | power_on_req | watchdog_timeout | low_voltage_req;
    s_next.rst_out.init_start  = 1'b0;
    s_next.rst_out.stack_clear = 1'b0;
    if (any_src)
    begin
      s_next.rst_cnt  = RST_TICKS;
      s_next.in_reset = 1'b1;
    end
    else if (s_reg.in_reset && int_tick)
    begin
      // delay timed by the internal clock, backup at power on
      if (s_reg.rst_cnt <= 16'h0001)
      begin
        s_next.rst_cnt             = 16'h0000;
        s_next.in_reset            = 1'b0;
        s_next.rst_out.init_start  = 1'b1;
        s_next.rst_out.stack_clear = 1'b1;
      end
      else
      begin
        s_next.rst_cnt = s_reg.rst_cnt - 16'h0001;
      end
    end
    s_next.rst_out.core_reset    = s_next.in_reset;
    s_next.rst_out.io_pullup_all = s_next.in_reset;
    s_next.rst_out.reset_vector  = `RESET_VECTOR;

    // apb: read data captured in setup, write at access
    if (apb_setup)
    begin
      s_next.prdata  = addr_hit ? {24'h000000, s_reg.ctl_reg} : 32'h00000000;
      s_next.pslverr = ~addr_hit;
    end
    if (s_reg.in_reset)
    begin
      s_next.ctl_reg = `CONV_CTL_RESET;
    end
    else if (apb_write && addr_hit)
    begin
      s_next.ctl_reg = pwdata[7:0];
    end
  end

  // ============================================================
  // state register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_reg          <= '0;
      s_reg.ctl_reg  <= `CONV_CTL_RESET;
      s_reg.rst_s1   <= 1'b1;
      s_reg.rst_s2   <= 1'b1;
      s_reg.main_sel <= 1'b0;
      s_reg.rst_cnt  <= RST_TICKS;
      s_reg.in_reset <= 1'b1;
      s_reg.rs_state <= clk_safeguard_pkg::RS_IDLE;
      s_reg.rst_out.core_reset    <= 1'b1;
      s_reg.rst_out.io_pullup_all <= 1'b1;
      s_reg.rst_out.reset_vector  <= `RESET_VECTOR;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ============================================================
  // outputs
  assign main_osc_enable   = ~stop_req(s_reg.ctl_reg, safeguard_enable_option);
  assign backup_osc_enable = safeguard_enable_option & ~s_reg.main_sel;
  assign ticks             = s_reg.ticks;
  assign rst_out           = s_reg.rst_out;
  assign prdata            = s_reg.prdata;
  assign pslverr           = s_reg.pslverr & psel & penable;
  assign pready            = psel & penable;  // every access ends in one cycle

endmodule

// File: design/clk_safeguard_cfg.svh
`ifndef CLK_SAFEGUARD_CFG_SVH
`define CLK_SAFEGUARD_CFG_SVH

// ============================================================
// register map (index = printed offset, byte address = 4 * index)
`define CONV_CTL_INDEX        12'h0D1
`define CONV_CTL_ADDR         12'h344
`define CONV_CTL_RESET        8'h40
`define MAIN_OSC_STOP_BIT     2

// ============================================================
// clock dividers
`define PERIPH_DIV            4'hC
`define CORE_DIV              4'hD
`define INSTR_CYC_SHORT       3'h2
`define INSTR_CYC_MID         3'h4
`define INSTR_CYC_LONG        3'h5

// ============================================================
// reset vector
`define RESET_VECTOR          12'hFFE

// ============================================================
// timing, times in ns, counts in cycles of clk, reset delay in internal clock ticks
`define CLK_PERIOD_NS         40
`define BACKUP_PERIOD_NS      2500
`define BACKUP_PERIOD_CYC     (`BACKUP_PERIOD_NS / `CLK_PERIOD_NS)
`define MISS_EDGE_NS          1000
`define MISS_EDGE_CYC         (`MISS_EDGE_NS / `CLK_PERIOD_NS)
`define OSG_MIN_PERIOD_NS     125
`define OSG_MIN_PERIOD_CYC    ((`OSG_MIN_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OSC_STARTUP_NS        4000
`define OSC_STARTUP_CYC       ((`OSC_STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_DELAY_TICKS     2048

`endif

// File: design/clk_safeguard_pkg.sv
package clk_safeguard_pkg;

  // instruction length selector
  typedef enum logic [1:0] {LEN_TWO, LEN_FOUR, LEN_FIVE, LEN_RSVD} instr_len_t;

  // restart sequence of the main oscillator
  typedef enum logic [1:0] {RS_IDLE, RS_STARTUP, RS_WAIT_INSTR} restart_t;

  // clock enables handed to the rest of the chip
  typedef struct packed {
    logic int_tick;
    logic periph_tick;
    logic mcycle_tick;
    logic instr_done;
  } clk_ticks_t;

  // reset state handed to the rest of the chip
  typedef struct packed {
    logic        core_reset;
    logic        io_pullup_all;
    logic        init_start;
    logic        stack_clear;
    logic [11:0] reset_vector;
  } rst_out_t;

  // all state of the block
  typedef struct packed {
    logic [7:0]  ctl_reg;
    logic        rst_s1;
    logic        rst_s2;
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_prev;
    logic [7:0]  miss_cnt;
    logic        main_lost;
    logic [7:0]  bk_cnt;
    logic        main_sel;
    restart_t    rs_state;
    logic [7:0]  start_cnt;
    logic [3:0]  gap_cnt;
    logic [3:0]  p12_cnt;
    logic [3:0]  c13_cnt;
    logic [2:0]  mc_cnt;
    logic [15:0] rst_cnt;
    logic        in_reset;
    logic [31:0] prdata;
    logic        pslverr;
    clk_ticks_t  ticks;
    rst_out_t    rst_out;
  } state_t;

endpackage

// File: testbench/osc_rst_src.sv
`timescale 1ns/1ns
// ====================
// crystal and external reset source
module osc_rst_src (
  // clock
  input  wire logic       clk,
  // crystal control
  input  wire logic       osc_en,
  input  wire logic       dead,
  input  wire logic [3:0] half,
  output logic            osc,
  // reset pin request
  input  wire logic       pin_req,
  output logic            pin_n
);
  logic [3:0] cnt = 4'h0;
  initial osc = 1'b0;
  // pin is pulled up when nobody drives it low
  assign pin_n = !pin_req;
  // crystal toggles while powered, stands low when stopped or broken
  always @(posedge clk)
    if (!osc_en || dead)
    begin
      osc <= 1'b0;
      cnt <= 4'h0;
    end
    else if (cnt >= half - 4'h1)
    begin
      osc <= !osc;
      cnt <= 4'h0;
    end
    else
      cnt <= cnt + 4'h1;
endmodule

// File: testbench/clk_guard_chk.sv
`timescale 1ns/1ns
// ====================
// port checker
module clk_guard_chk #(
  parameter int RESET_DELAY_TICKS = 8
) (
  // clock and reset
  input wire logic                     clk,
  input wire logic                     rst_n,
  // register bus
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [11:0]              paddr,
  input wire logic [31:0]              pwdata,
  // oscillator and reset pins
  input wire logic                     safeguard_enable_option,
  input wire logic                     main_osc_enable,
  input wire logic                     backup_osc_enable,
  input wire logic                     reset_pin_n,
  // core side
  input clk_safeguard_pkg::clk_ticks_t ticks,
  input clk_safeguard_pkg::rst_out_t   rst_out
);
  logic [4:0] n12, n13;
  logic       s12, s13, stop_req;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign stop_req = pwdata[2] && safeguard_enable_option;
  // int ticks since the last divided tick, outside reset only
  always_ff @(posedge clk)
    if (!rst_n || rst_out.core_reset)
    begin
      n12 <= 5'h00;
      n13 <= 5'h00;
      s12 <= 1'b0;
      s13 <= 1'b0;
    end
    else
    begin
      n12 <= ticks.periph_tick ? 5'h00 : n12 + 5'(ticks.int_tick);
      n13 <= ticks.mcycle_tick ? 5'h00 : n13 + 5'(ticks.int_tick);
      s12 <= s12 | ticks.periph_tick;
      s13 <= s13 | ticks.mcycle_tick;
    end
  a_opt_gates_osc : assert property (
    !safeguard_enable_option |-> main_osc_enable && !backup_osc_enable)
    else $error("oscillator enables wrong with option low");
  a_pullup_in_reset : assert property (
    rst_out.io_pullup_all == rst_out.core_reset) else $error("pull-up not tied to reset");
  a_init_on_exit : assert property (
    rst_out.init_start |-> rst_out.stack_clear && !rst_out.core_reset
      && $past(rst_out.core_reset) && rst_out.reset_vector == 12'hFFE)
    else $error("init pulse wrong");
  a_pin_holds_reset : assert property (
    (!reset_pin_n) [*5] |-> rst_out.core_reset) else $error("reset left with pin low");
  a_periph_div : assert property (
    ticks.periph_tick && s12 |-> n12 + 5'(ticks.int_tick) == 5'h0C)
    else $error("peripheral tick spacing wrong");
  a_core_div : assert property (
    ticks.mcycle_tick && s13 |-> n13 + 5'(ticks.int_tick) == 5'h0D)
    else $error("machine cycle spacing wrong");
  a_stop_bit_write : assert property (
    psel && penable && pwrite && paddr == 12'h344 && !rst_out.core_reset
      |=> main_osc_enable == !$past(stop_req)) else $error("stop bit not applied");
  a_int_spacing : assert property (
    safeguard_enable_option && ticks.int_tick |=> (!ticks.int_tick) [*3])
    else $error("internal clock too fast");
  c_init : cover property (rst_out.init_start);
  c_backup : cover property ($rose(backup_osc_enable));
  c_instr : cover property (ticks.instr_done);
endmodule

bind clock_safeguard_and_reset_input clk_guard_chk #(.RESET_DELAY_TICKS(RESET_DELAY_TICKS)) chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .safeguard_enable_option(safeguard_enable_option),
  .main_osc_enable(main_osc_enable), .backup_osc_enable(backup_osc_enable),
  .reset_pin_n(reset_pin_n), .ticks(ticks), .rst_out(rst_out));

// File: testbench/test_clock_safeguard_and_reset_input.sv
`timescale 1ns/1ns
// ====================
// bench top
module test_clock_safeguard_and_reset_input;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic opt = 1'b1, dead = 1'b1, pwr = 1'b0, wdog = 1'b0, lv = 1'b0, pin_req = 1'b0;
  logic pready, pslverr, osc, osc_en, bk_en, pin_n, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] half = 4'h2;
  clk_safeguard_pkg::instr_len_t len = clk_safeguard_pkg::LEN_TWO;
  clk_safeguard_pkg::clk_ticks_t ticks;
  clk_safeguard_pkg::rst_out_t ro;
  int num_errors = 0, checked = 0, cycles = 0, n;
  clock_safeguard_and_reset_input #(.RESET_DELAY_TICKS(8)) uut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_osc_in(osc), .safeguard_enable_option(opt), .main_osc_enable(osc_en),
    .backup_osc_enable(bk_en), .reset_pin_n(pin_n), .power_on_req(pwr),
    .watchdog_timeout(wdog), .low_voltage_req(lv), .instr_len(len), .ticks(ticks),
    .rst_out(ro));
  osc_rst_src xtal (.clk(clk), .osc_en(osc_en), .dead(dead), .half(half), .osc(osc),
    .pin_req(pin_req), .pin_n(pin_n));
  // 25 MHz clock
  always #20 clk = !clk;
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      num_errors++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("errors %0d of %0d checks", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // wait for backup enable (s 0) or core reset (s 1) to reach v
  task automatic wait_for(input int s, input logic v, input int lim);
    n = 0;
    while ((s != 0 ? ro.core_reset : bk_en) !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    cmp(n < lim, 1);
  endtask
  task automatic count(input int c);
    n = 0;
    repeat (c)
    begin
      @(posedge clk);
      if (ticks.int_tick === 1'b1) n++;
    end
  endtask
  // power on from the backup clock, crystal arrives during reset
  task automatic t_boot;
    int m;
    m = 0;
    repeat (20) @(posedge clk);
    cmp(bk_en, 1);
    dead <= 1'b0;
    while (ro.core_reset !== 1'b0 && cycles < 8000)
    begin
      @(posedge clk);
      if (ticks.int_tick === 1'b1) m++;
    end
    cmp(ro.init_start & ro.stack_clear, 1);
    cmp(ro.reset_vector, 32'hFFE);
    cmp(m >= 8, 1);
    wait_for(0, 0, 12000);
  endtask
  // register access, stop bit and restart of the crystal
  task automatic t_regs;
    apb(0, 12'h344, 0);
    cmp(rd, 32'h40);
    apb(0, 12'h348, 0);
    cmp({rd, er}, 33'h1);
    apb(1, 12'h344, 32'hBB);
    apb(0, 12'h344, 0);
    cmp(rd, 32'hBB);
    apb(1, 12'h344, 32'h44);
    @(posedge clk);
    cmp(osc_en, 0);
    wait_for(0, 1, 200);
    apb(1, 12'h344, 32'h40);
    @(posedge clk);
    cmp(osc_en, 1);
    repeat (95) @(posedge clk);
    cmp(bk_en, 1);
    wait_for(0, 0, 12000);
  endtask
  // crystal dies, backup takes over and code keeps running slowly
  task automatic t_lost;
    dead <= 1'b1;
    repeat (20) @(posedge clk);
    cmp(bk_en, 0);
    wait_for(0, 1, 100);
    count(200);
    cmp(n inside {[3:4]}, 1);
    dead <= 1'b0;
    wait_for(0, 0, 12000);
  endtask
  // spiking crystal is thinned out
  task automatic t_spike;
    half <= 4'h1;
    count(200);
    cmp(n <= 50 && n >= 30, 1);
    half <= 4'h2;
  endtask
  // mcycles per instruction for each length code
  task automatic t_instr;
    int e[4] = '{2, 4, 5, 5};
    int d, m;
    for (int i = 0; i < 4; i++)
    begin
      len <= clk_safeguard_pkg::instr_len_t'(i);
      d = 0;
      m = 0;
      while (d < 3 && cycles < 80000)
      begin
        @(posedge clk);
        if (ticks.mcycle_tick === 1'b1) m++;
        if (ticks.instr_done === 1'b1)
        begin
          d++;
          if (d == 3) cmp(m, e[i]);
          m = 0;
        end
      end
    end
  endtask
  // option low: stop bit has no effect, no backup, clock keeps running from the crystal
  task automatic t_noopt;
    opt <= 1'b0;
    apb(1, 12'h344, 32'h44);
    @(posedge clk);
    cmp({osc_en, bk_en}, 2'h2);
    count(100);
    cmp(n >= 20, 1);
    apb(1, 12'h344, 32'h40);
    opt <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // each reset source, then a long pin reset with the crystal stopped
  task automatic t_resets;
    for (int i = 0; i < 4; i++)
    begin
      {pwr, wdog, lv, pin_req} <= 4'h8 >> i;
      repeat (2) @(posedge clk);
      {pwr, wdog, lv, pin_req} <= 4'h0;
      repeat (4) @(posedge clk);
      cmp({ro.core_reset, ro.io_pullup_all}, 2'h3);
      wait_for(1, 0, 3000);
    end
    apb(1, 12'h344, 32'h44);
    pin_req <= 1'b1;
    repeat (40) @(posedge clk);
    cmp({ro.core_reset, osc_en}, 2'h3);
    pin_req <= 1'b0;
    wait_for(1, 0, 12000);
    apb(0, 12'h344, 0);
    cmp(rd, 32'h40);
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_boot;
    t_regs;
    t_lost;
    t_spike;
    t_noopt;
    t_instr;
    t_resets;
    give_verdict;
  end
endmodule
